// ==== rtl/iop_pad_config.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Test port enabled when test clock low
// - Pull-ups on clock, mode, data-in when enabled
// - Test clock pull-up on throughout reset
// - Test data out driven, no pull-up
// - Disabled test port frees pins as lines
// - Reset pin carries single-wire debug data
// - Two-wire pins open-drain, filtered when assigned
// - Per-line pull-up, pull-down, drive strength
// - Reset: inputs, pulls disabled except test clock pull-up
// - Reset: drive strength lowest
// - Analog function forces pulls off, except test-port pull-ups and the reset test clock pull-up
// - Four ports with documented line sets
// - Last listed function wins on conflict
// - Debug data only once debug enabled
module iop_pad_config
  import iop_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LINES-1:0] padIn,
  output logic [NUM_LINES-1:0] padOut,
  output logic [NUM_LINES-1:0] padOe,
  output logic [NUM_LINES-1:0] padPullUp,
  output logic [NUM_LINES-1:0] padPullDn,
  output logic [NUM_LINES*DRV_W-1:0] padDrive,
  output logic [NUM_LINES-1:0] padFilter,
  input wire logic [NUM_LINES-1:0] periphOut,
  input wire logic [NUM_LINES-1:0] periphOe,
  output logic [NUM_LINES-1:0] periphIn,
  input wire logic [NUM_LINES-1:0] auxEn,
  input wire logic [NUM_LINES-1:0] auxOut,
  input wire logic [NUM_LINES-1:0] auxOe,
  output logic jtagEnabled,
  output logic jtagTck,
  output logic jtagTms,
  output logic jtagTdi,
  input wire logic jtagTdo,
  input wire logic rstPadIn,
  output logic rstPadOut,
  output logic rstPadOe,
  input wire logic dbgEnable,
  input wire logic dbgOut,
  input wire logic dbgOe,
  output logic dbgDataIn
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] portMask(input int p);
    case (p)
      0: portMask = PORT_A_MASK;
      1: portMask = PORT_B_MASK;
      2: portMask = PORT_C_MASK;
      default: portMask = PORT_D_MASK;
    endcase
  endfunction

  function automatic logic isTestPin(input int line);
    isTestPin = (line == TCK_LINE) || (line == TDI_LINE) || (line == TDO_LINE) ||
      (line == TMS_LINE);
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] padSync;
  logic rstPadSync;

  iop_sync #(
    .WIDTH(NUM_LINES)
  ) u_pad_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .asyncIn(padIn),
    .syncOut(padSync)
  );

  iop_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .asyncIn(rstPadIn),
    .syncOut(rstPadSync)
  );

  // ---------------------------------------------------------------
  // Test-port detection at reset release
  // ---------------------------------------------------------------
  iop_boot_t boot_ff;
  iop_boot_t nxt_boot;
  logic jtagEn_ff;
  logic inReset_ff;

  always_comb begin
    case (boot_ff)
      ST_WAIT1: nxt_boot = ST_WAIT2;
      ST_WAIT2: nxt_boot = ST_SAMPLE;
      ST_SAMPLE: nxt_boot = ST_RUN;
      ST_RUN: nxt_boot = ST_RUN;
      default: nxt_boot = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_ff <= ST_WAIT1;
    end else begin
      boot_ff <= nxt_boot;
    end
  end

  // Decision taken once, after the synchroniser has filled
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      jtagEn_ff <= 1'b0;
      inReset_ff <= 1'b1;
    end else if (boot_ff == ST_SAMPLE) begin
      jtagEn_ff <= ~padSync[TCK_LINE];
      inReset_ff <= 1'b0;
    end
  end

  assign jtagEnabled = jtagEn_ff;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic [31:0] cfg_ff [0:NUM_PORTS-1][0:NUM_CFG-1];
  logic [31:0] prdata_ff;
  logic [1:0] selPort;
  logic [3:0] selReg;
  logic isStatus;
  logic inPortSpace;
  logic addrOk;
  logic wrEn;
  logic [31:0] nxt_rdata;

  assign selPort = paddr[PORT_STRIDE_LSB+1:PORT_STRIDE_LSB];
  assign selReg = paddr[5:2];
  assign isStatus = (paddr == STATUS_ADDR);
  assign inPortSpace = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
    (selReg <= REG_PIN);
  assign addrOk = isStatus || inPortSpace;
  assign wrEn = psel && penable && pwrite && inPortSpace && (selReg != REG_PIN);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (isStatus) begin
      nxt_rdata[STATUS_JTAG_BIT] = jtagEn_ff;
      nxt_rdata[STATUS_BOOT_BIT] = inReset_ff;
    end else if (inPortSpace) begin
      if (selReg == REG_PIN) begin
        nxt_rdata = padSync[selPort*PORT_W +: PORT_W] & portMask(int'(selPort));
      end else begin
        nxt_rdata = cfg_ff[selPort][selReg];
      end
    end
  end

  // Read data is captured in the setup cycle, ready in the access phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= nxt_rdata;
    end
  end

  assign prdata = prdata_ff;

  // ---------------------------------------------------------------
  // Per-line configuration storage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int r = 0; r < NUM_CFG; r++) begin
          if (r == int'(REG_GPIO_EN)) begin
            cfg_ff[p][r] <= GPIO_EN_RESET;
          end else begin
            cfg_ff[p][r] <= CFG_ZERO_RESET;
          end
        end
      end
    end else if (wrEn) begin
      // Unimplemented lines are written as zero; the GPIO enable reset value sets them to one
      cfg_ff[selPort][selReg] <= pwdata & portMask(int'(selPort));
    end
  end

  // ---------------------------------------------------------------
  // Pad control per line
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] nxt_out;
  logic [NUM_LINES-1:0] nxt_oe;
  logic [NUM_LINES-1:0] nxt_pu;
  logic [NUM_LINES-1:0] nxt_pd;
  logic [NUM_LINES*DRV_W-1:0] nxt_drv;
  logic [NUM_LINES-1:0] nxt_filt;

  always_comb begin
    int p;
    int b;
    logic useGpio;
    logic selOut;
    logic selOe;
    logic twoWire;
    logic analog;
    logic [31:0] lineMask;
    p = 0;
    b = 0;
    useGpio = 1'b0;
    selOut = 1'b0;
    selOe = 1'b0;
    twoWire = 1'b0;
    analog = 1'b0;
    lineMask = 32'h00000000;
    nxt_out = '0;
    nxt_oe = '0;
    nxt_pu = '0;
    nxt_pd = '0;
    nxt_drv = '0;
    nxt_filt = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      p = i / PORT_W;
      b = i % PORT_W;
      lineMask = portMask(p);
      if (lineMask[b]) begin
        useGpio = cfg_ff[p][REG_GPIO_EN][b];
        if (auxEn[i]) begin
          // Later function in the list takes the pin
          selOut = auxOut[i];
          selOe = auxOe[i];
        end else if (useGpio) begin
          selOut = cfg_ff[p][REG_OUT][b];
          selOe = cfg_ff[p][REG_OE][b];
        end else begin
          selOut = periphOut[i];
          selOe = periphOe[i];
        end
        twoWire = cfg_ff[p][REG_TWOWIRE][b] && !useGpio && !auxEn[i];
        analog = cfg_ff[p][REG_ANALOG][b];
        if (twoWire) begin
          // Drive low only, release for high
          nxt_out[i] = 1'b0;
          nxt_oe[i] = selOe && !selOut;
          nxt_filt[i] = 1'b1;
        end else begin
          nxt_out[i] = selOut;
          nxt_oe[i] = selOe;
        end
        nxt_pu[i] = cfg_ff[p][REG_PULLUP][b] && !analog;
        nxt_pd[i] = cfg_ff[p][REG_PULLDN][b] && !analog;
        nxt_drv[i*DRV_W +: DRV_W] = {cfg_ff[p][REG_DRV1][b], cfg_ff[p][REG_DRV0][b]};
        if (jtagEn_ff && isTestPin(i)) begin
          if (i == TDO_LINE) begin
            nxt_out[i] = jtagTdo;
            nxt_oe[i] = 1'b1;
            nxt_pu[i] = 1'b0;
          end else begin
            nxt_out[i] = 1'b0;
            nxt_oe[i] = 1'b0;
            nxt_pu[i] = 1'b1;
          end
          nxt_pd[i] = 1'b0;
          nxt_filt[i] = 1'b0;
        end
        if (inReset_ff && (i == TCK_LINE)) begin
          nxt_pu[i] = 1'b1;
        end
      end
    end
  end

  // Registered pad controls: a write shows one edge later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      padOut <= '0;
      padOe <= '0;
      padPullUp <= PAD_PU_RESET;
      padPullDn <= '0;
      padDrive <= '0;
      padFilter <= '0;
    end else begin
      padOut <= nxt_out;
      padOe <= nxt_oe;
      padPullUp <= nxt_pu;
      padPullDn <= nxt_pd;
      padDrive <= nxt_drv;
      padFilter <= nxt_filt;
    end
  end

  // ---------------------------------------------------------------
  // Input fan-out
  // ---------------------------------------------------------------
  logic [NUM_LINES-1:0] lineMaskAll;

  always_comb begin
    lineMaskAll = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      lineMaskAll[p*PORT_W +: PORT_W] = portMask(p);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      periphIn <= '0;
      jtagTck <= 1'b0;
      jtagTms <= 1'b0;
      jtagTdi <= 1'b0;
    end else begin
      // Test pins always reach the line logic; test outputs follow them only while the port is on
      periphIn <= padSync & lineMaskAll;
      jtagTck <= jtagEn_ff && padSync[TCK_LINE];
      jtagTms <= jtagEn_ff && padSync[TMS_LINE];
      jtagTdi <= jtagEn_ff && padSync[TDI_LINE];
    end
  end

  // ---------------------------------------------------------------
  // Reset pin as single-wire debug line
  // ---------------------------------------------------------------
  // Board side must not drive the pin while debug owns it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPadOut <= 1'b0;
      rstPadOe <= 1'b0;
      dbgDataIn <= 1'b0;
    end else begin
      rstPadOut <= dbgEnable && dbgOut;
      rstPadOe <= dbgEnable && dbgOe;
      dbgDataIn <= dbgEnable && rstPadSync;
    end
  end

endmodule

// ==== rtl/iop_pkg.sv ====
package iop_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 32;
  localparam int NUM_LINES = NUM_PORTS * PORT_W;
  localparam int DRV_W = 2;
  localparam int SYNC_STAGES = 2;

  // Implemented lines of each port
  localparam logic [31:0] PORT_A_MASK = 32'h3ff9ffff;
  localparam logic [31:0] PORT_B_MASK = 32'hffffffff;
  localparam logic [31:0] PORT_C_MASK = 32'hffffffff;
  localparam logic [31:0] PORT_D_MASK = 32'h7fffffff;

  // ---------------------------------------------------------------
  // Test-port pin placement (flattened line index, port*32+bit)
  // ---------------------------------------------------------------
  localparam int TCK_LINE = 0;
  localparam int TDI_LINE = 1;
  localparam int TDO_LINE = 2;
  localparam int TMS_LINE = 3;

  // Pull-up on the test clock line while reset is held
  localparam logic [NUM_LINES-1:0] PAD_PU_RESET = 128'h1;

  // ---------------------------------------------------------------
  // Register map: 0x40 bytes per port, status word above
  // ---------------------------------------------------------------
  localparam int NUM_CFG = 9;
  localparam logic [3:0] REG_GPIO_EN = 4'h0;
  localparam logic [3:0] REG_OUT = 4'h1;
  localparam logic [3:0] REG_OE = 4'h2;
  localparam logic [3:0] REG_PULLUP = 4'h3;
  localparam logic [3:0] REG_PULLDN = 4'h4;
  localparam logic [3:0] REG_DRV0 = 4'h5;
  localparam logic [3:0] REG_DRV1 = 4'h6;
  localparam logic [3:0] REG_ANALOG = 4'h7;
  localparam logic [3:0] REG_TWOWIRE = 4'h8;
  localparam logic [3:0] REG_PIN = 4'h9;
  localparam logic [11:0] STATUS_ADDR = 12'h100;
  localparam int PORT_STRIDE_LSB = 6;
  localparam int STATUS_JTAG_BIT = 0;
  localparam int STATUS_BOOT_BIT = 1;

  // Reset values of the per-port configuration words
  localparam logic [31:0] GPIO_EN_RESET = 32'hffffffff;
  localparam logic [31:0] CFG_ZERO_RESET = 32'h00000000;

  typedef enum logic [3:0] {
    ST_WAIT1 = 4'b0001,
    ST_WAIT2 = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_RUN = 4'b1000
  } iop_boot_t;

endpackage

// ==== rtl/iop_sync.sv ====
`timescale 1ns/1ps
module iop_sync
  import iop_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;

endmodule

// ==== test/iop_pad_config_assertions.sv ====
`timescale 1ns/1ps
module iop_pad_checker
  import iop_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [NUM_LINES-1:0] padIn,
  input wire logic [NUM_LINES-1:0] padOut,
  input wire logic [NUM_LINES-1:0] padOe,
  input wire logic [NUM_LINES-1:0] padPullUp,
  input wire logic [NUM_LINES-1:0] padPullDn,
  input wire logic [NUM_LINES*DRV_W-1:0] padDrive,
  input wire logic [NUM_LINES-1:0] periphIn,
  input wire logic [NUM_LINES-1:0] auxEn,
  input wire logic [NUM_LINES-1:0] auxOut,
  input wire logic [NUM_LINES-1:0] auxOe,
  input wire logic jtagEnabled,
  input wire logic jtagTdo,
  input wire logic rstPadOe,
  input wire logic dbgEnable,
  input wire logic dbgDataIn
);
  logic [2:0] bootCnt_ff;

  // Edges since reset release, saturating
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bootCnt_ff <= 3'h0;
    end else if (bootCnt_ff != 3'h7) begin
      bootCnt_ff <= bootCnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  reset_dflt_a: assert property (
    bootCnt_ff inside {[3'h1:3'h3]} |-> padOe == 128'h0 && padPullDn == 128'h0
    && padDrive == 256'h0 && padPullUp == PAD_PU_RESET) else $error("pad default lost");
  detect_a: assert property (
    bootCnt_ff == 3'h3 |-> jtagEnabled == !$past(padIn[TCK_LINE], 3))
    else $error("test port choice wrong");
  choice_hold_a: assert property (
    bootCnt_ff >= 3'h4 |-> $stable(jtagEnabled)) else $error("test port choice moved");
  tap_pulls_a: assert property (
    $past(jtagEnabled) |-> padPullUp[TCK_LINE] && padPullUp[TDI_LINE] && padPullUp[TMS_LINE]
    && !padOe[TCK_LINE] && !padOe[TMS_LINE] && !padPullDn[TDI_LINE]) else $error("tap pulls");
  tdo_drive_a: assert property (
    $past(jtagEnabled) |-> padOe[TDO_LINE] && !padPullUp[TDO_LINE]
    && padOut[TDO_LINE] == $past(jtagTdo)) else $error("tdo pad wrong");
  aux_prio_a: assert property (
    bootCnt_ff >= 3'h4 && auxEn[32] |=> padOe[32] == $past(auxOe[32])
    && padOut[32] == $past(auxOut[32])) else $error("aux function lost the pin");
  dbg_gate_a: assert property (
    !dbgEnable |=> !dbgDataIn && !rstPadOe) else $error("debug line active early");
  unimpl_a: assert property (
    periphIn[18:17] == 2'h0 && periphIn[31:30] == 2'h0 && !periphIn[127])
    else $error("missing line seen");
endmodule

bind iop_pad_config iop_pad_checker iopChk (.ref_clk, .arst_n, .padIn, .padOut, .padOe,
  .padPullUp, .padPullDn, .padDrive, .periphIn, .auxEn, .auxOut, .auxOe, .jtagEnabled,
  .jtagTdo, .rstPadOe, .dbgEnable, .dbgDataIn);

// ==== test/iop_board_model.sv ====
`timescale 1ns/1ps
module iop_board_model
  import iop_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [NUM_LINES-1:0] padOut,
  input wire logic [NUM_LINES-1:0] padOe,
  input wire logic [NUM_LINES-1:0] padPullUp,
  input wire logic [NUM_LINES-1:0] padPullDn,
  input wire logic [NUM_LINES-1:0] extEn,
  input wire logic [NUM_LINES-1:0] extDrv,
  output logic [NUM_LINES-1:0] padIn,
  input wire logic rstPadOut,
  input wire logic rstPadOe,
  input wire logic probeEn,
  input wire logic probeDrv,
  output logic rstPadIn
);
  logic flip_ff = 1'b0;

  always_ff @(posedge ref_clk) begin
    flip_ff <= !flip_ff;
  end

  // Floating lines wander so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extDrv[i]
        : padPullUp[i] | (!padPullDn[i] & flip_ff);
    end
  end

  // Board keeps off the reset line; only the probe or the pull-up
  assign rstPadIn = rstPadOe ? rstPadOut : probeEn ? probeDrv : 1'b1;
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import iop_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, sErr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [NUM_LINES-1:0] padIn, padOut, padOe, padPullUp, padPullDn, padFilter, periphIn;
  logic [NUM_LINES-1:0] periphOut = 128'h0, periphOe = 128'h0, auxEn = 128'h0;
  logic [NUM_LINES-1:0] auxOut = 128'h0, auxOe = 128'h0, extEn = 128'h1, extDrv = 128'h1;
  logic [NUM_LINES*DRV_W-1:0] padDrive;
  logic jtagEnabled, jtagTck, jtagTms, jtagTdi, rstPadIn, rstPadOut, rstPadOe, dbgDataIn;
  logic jtagTdo = 1'b0, dbgEnable = 1'b0, dbgOut = 1'b0, dbgOe = 1'b0;
  logic probeEn = 1'b1, probeDrv = 1'b1;
  int err_count = 0, n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;

  iop_pad_config DUT (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .padIn, .padOut, .padOe, .padPullUp, .padPullDn,
    .padDrive, .padFilter, .periphOut, .periphOe, .periphIn, .auxEn, .auxOut, .auxOe,
    .jtagEnabled, .jtagTck, .jtagTms, .jtagTdi, .jtagTdo, .rstPadIn, .rstPadOut,
    .rstPadOe, .dbgEnable, .dbgOut, .dbgOe, .dbgDataIn);
  iop_board_model board (.ref_clk, .padOut, .padOe, .padPullUp, .padPullDn, .extEn,
    .extDrv, .padIn, .rstPadOut, .rstPadOe, .probeEn, .probeDrv, .rstPadIn);

  task automatic end_sim;
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] s);
    n_tests++;
    if (e !== s) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1 && ++n < 20);
    rdv = prdata;
    sErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", 256'(e), 256'(rdv));
  endtask

  function automatic logic [11:0] ad(input logic [1:0] p, input logic [3:0] r);
    return {4'h0, p, r, 2'h0};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic rst(input logic tck);
    @(posedge ref_clk);
    extDrv[0] <= tck;
    arst_n <= 1'b0;
    auxEn <= 128'h0;
    tick(3);
    chk("resetPull", 256'(PAD_PU_RESET), 256'(padPullUp));
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    tick(6);
  endtask

  initial begin
    rst(1'b1);
    chk("tstEn", 256'h0, 256'(jtagEnabled));
    chk("pulls", 256'h0, {padPullUp, padPullDn});
    chk("drvOe", 256'h0, padDrive | 256'(padOe));
    rd(12'h100, 32'h0);
    apb(1'b1, ad(2'h0, REG_OUT), 32'h5);
    apb(1'b1, ad(2'h0, REG_OE), 32'hf);
    #1;
    chk("oeEarly", 256'h0, 256'(padOe[3:0]));
    tick(1);
    chk("gpio", 256'hf5, 256'({padOe[3:0], padOut[3:0]}));
    apb(1'b1, ad(2'h1, REG_PULLUP), 32'ha5a5a5a5);
    apb(1'b1, ad(2'h1, REG_PULLDN), 32'h0000ff00);
    apb(1'b1, ad(2'h3, REG_DRV0), 32'h0000ffff);
    apb(1'b1, ad(2'h3, REG_DRV1), 32'h00ff00ff);
    apb(1'b1, ad(2'h0, REG_PULLUP), 32'hffffffff);
    tick(1);
    chk("pu", 256'({32'ha5a5a5a5, 32'h3ff9ffff}), 256'(padPullUp));
    chk("pd", 256'({32'h0000ff00, 32'h0}), 256'(padPullDn));
    chk("drive", {64'h0000aaaa5555ffff, 192'h0}, padDrive);
    chk("lineIn", 256'h5, 256'(periphIn[3:0]));
    rd(ad(2'h0, REG_PULLUP), 32'h3ff9ffff);
    rd(ad(2'h0, REG_PIN), 32'h3ff9fff5);
    apb(1'b1, ad(2'h1, REG_ANALOG), 32'h0000ffff);
    tick(1);
    chk("analog", 256'ha5a500000000, 256'({padPullUp[63:32], padPullDn[47:32]}));
    rd(ad(2'h1, REG_PULLUP), 32'ha5a5a5a5);
    apb(1'b1, ad(2'h2, REG_GPIO_EN), 32'hfffffff3);
    apb(1'b1, ad(2'h2, REG_TWOWIRE), 32'h00000004);
    periphOe[67:66] <= 2'h3;
    periphOut[67:66] <= 2'h2;
    tick(2);
    chk("twLow", 256'h39, 256'({padOe[67:66], padOut[67:66], padFilter[67:66]}));
    @(posedge ref_clk);
    periphOut[66] <= 1'b1;
    auxEn[32] <= 1'b1;
    auxOe[32] <= 1'b1;
    auxOut[32] <= 1'b1;
    tick(2);
    chk("twHigh", 256'h29, 256'({padOe[67:66], padOut[67:66], padFilter[67:66]}));
    chk("aux", 256'h3, 256'({padOe[32], padOut[32]}));
    apb(1'b0, 12'h104, 32'h0);
    chk("unmapped", 256'h100000000, 256'({sErr, rdv}));
    tick(4);
    chk("dbgOff", 256'h0, 256'({dbgDataIn, rstPadOe}));
    @(posedge ref_clk);
    dbgEnable <= 1'b1;
    tick(4);
    chk("dbgIn", 256'h1, 256'(dbgDataIn));
    @(posedge ref_clk);
    probeEn <= 1'b0;
    dbgOe <= 1'b1;
    tick(4);
    chk("dbgOut", 256'h2, 256'({rstPadOe, rstPadOut}));
    rst(1'b0);
    chk("tstEn", 256'h1, 256'(jtagEnabled));
    rd(12'h100, 32'h1);
    jtagTdo <= 1'b1;
    extDrv[0] <= 1'b1;
    apb(1'b1, ad(2'h0, REG_OE), 32'h0000000f);
    apb(1'b1, ad(2'h0, REG_PULLDN), 32'h0000000f);
    tick(4);
    chk("tapPads", 256'h4b1, 256'({padOe[3:0], padPullUp[3:0], padPullDn[3],
      padPullDn[1:0], padOut[2]}));
    chk("tapIn", 256'hf, 256'({jtagEnabled, jtagTck, jtagTms, jtagTdi}));
    end_sim();
  end
endmodule
